// ---- bdc_drive_control.sv ----
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - bit 15 selects full-bridge when clear, dual half-bridge when set.
// - topology bit only changes while gate drive enable is clear.
// - fail-safe high and enable clear: all gate drivers disabled, passive turn-off.
// - fail-safe high and enable set: all gate drivers enabled per topology.
// - fail-safe falling low forces sink mode and clears enable.
// - while fail-safe is low, enable is frozen against serial writes.
// - watchdog fault sets its flag and clears enable.
// - while watchdog flag is set, enable is frozen against serial writes.
// - full-bridge: bit 13 turns active free-wheeling on or off.
// - dual half-bridge: free-wheeling enable bit is ignored.
// - drive control sits at address 0x03 with documented upper-byte field order.
module bdc_drive_control
	import bdc_pkg::*;
(
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	// serial port pins
	input  wire logic sck_i,
	input  wire logic cs_n_i,
	input  wire logic mosi_i,
	output logic      miso_o,
	// safety inputs
	input  wire logic failsafe_input_n_i,
	input  wire logic watchdog_fault_i,
	input  wire logic watchdog_clear_i,
	// gate driver control
	output logic      gate_drivers_enable_o,
	output logic      gate_sink_mode_o,
	output logic      bridge_topology_o,
	output logic      active_recirc_o,
	output logic      watchdog_fault_flag_o,
	output logic [15:0] drive_control_o
);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: stage one is read only by stage two
	bdc_spi_t   spi_s1_q;
	bdc_spi_t   spi_s2_q;
	bdc_spi_t   spi_s3_q;
	logic       fs_s1_q;
	logic       fs_s2_q;

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			spi_s1_q <= 3'h2;
			spi_s2_q <= 3'h2;
			spi_s3_q <= 3'h2;
			fs_s1_q  <= 1'h0;
			fs_s2_q  <= 1'h0;
		end
		else
		begin
			spi_s1_q <= '{sck: sck_i, cs_n: cs_n_i, mosi: mosi_i};
			spi_s2_q <= spi_s1_q;
			spi_s3_q <= spi_s2_q;
			fs_s1_q  <= failsafe_input_n_i;
			fs_s2_q  <= fs_s1_q;
		end
	end

	logic fs_low;
	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	assign fs_low   = ~fs_s2_q;
	assign sck_rise = spi_s2_q.sck & ~spi_s3_q.sck & ~spi_s2_q.cs_n;
	assign sck_fall = ~spi_s2_q.sck & spi_s3_q.sck & ~spi_s2_q.cs_n;
	assign cs_rise  = spi_s2_q.cs_n & ~spi_s3_q.cs_n;

	////////////////////////////////////////////////////////////////////////////
	// serial frame engine (mode 0, msb first)
	logic [FRAME_BITS-1:0] rx_q;
	logic [FRAME_BITS-1:0] rx_d;
	logic [4:0]            cnt_q;
	logic [4:0]            cnt_d;
	logic [DATA_BITS-1:0]  tx_q;
	logic [DATA_BITS-1:0]  tx_d;
	logic                  miso_d;
	logic [15:0]           rd_data;
	logic                  wr_commit;
	logic [DATA_BITS-1:0]  wdata;
	logic                  addr_hit;
	logic                  head_hit;

	bdc_ctrl_hi_t ctrl_q;
	bdc_ctrl_hi_t ctrl_d;
	logic [7:0]   lower_q;
	logic [7:0]   lower_d;

	assign addr_hit  = rx_q[ADDR_MSB:ADDR_LSB] == DRIVE_CONTROL_ADDR;
	// mid-frame the header still sits in the low bits; the upper field holds old data
	assign head_hit  = rx_q[ADDR_BITS-1:0] == DRIVE_CONTROL_ADDR;
	assign wdata     = rx_q[DATA_BITS-1:0];
	// only a whole frame commits; a short or long frame is dropped
	assign wr_commit = cs_rise && cnt_q == 5'(FRAME_BITS) && rx_q[WR_BIT] && addr_hit;
	assign rd_data   = {ctrl_q, lower_q};

	always_comb
	begin
		rx_d   = rx_q;
		cnt_d  = cnt_q;
		tx_d   = tx_q;
		miso_d = miso_o;
		if (spi_s2_q.cs_n)
		begin
			cnt_d  = 5'h00;
			miso_d = 1'h0;
		end
		else
		begin
			if (sck_rise)
			begin
				rx_d = {rx_q[FRAME_BITS-2:0], spi_s2_q.mosi};
				if (cnt_q != 5'h1F)
					cnt_d = cnt_q + 5'h01;
			end
			if (sck_fall && cnt_q == 5'(HEAD_BITS))
			begin
				// address known: unmapped addresses read back zero
				tx_d   = head_hit ? {rd_data[14:0], 1'h0} : 16'h0000;
				miso_d = head_hit ? rd_data[15] : 1'h0;
			end
			else if (sck_fall && cnt_q > 5'(HEAD_BITS))
			begin
				tx_d   = {tx_q[DATA_BITS-2:0], 1'h0};
				miso_d = tx_q[DATA_BITS-1];
			end
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			rx_q   <= 24'h000000;
			cnt_q  <= 5'h00;
			tx_q   <= 16'h0000;
			miso_o <= 1'h0;
		end
		else
		begin
			rx_q   <= rx_d;
			cnt_q  <= cnt_d;
			tx_q   <= tx_d;
			miso_o <= miso_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// drive control register and watchdog flag
	logic wdg_flag_q;
	logic wdg_flag_d;

	always_comb
	begin
		ctrl_d     = ctrl_q;
		lower_d    = lower_q;
		wdg_flag_d = wdg_flag_q;
		if (wr_commit)
		begin
			{ctrl_d.active_recirc_enable, ctrl_d.recirc_side_select, ctrl_d.leg_one_disable,
			 ctrl_d.leg_two_disable, ctrl_d.drain_monitor_scope,
			 ctrl_d.offstate_openload_test} = wdata[ACTIVE_RECIRC_ENABLE_BIT:8];
			lower_d = wdata[7:0];
			if (!ctrl_q.gate_drive_enable)
				ctrl_d.bridge_topology_select = wdata[TOPO_BIT];
			if (!fs_low && !wdg_flag_q)
				ctrl_d.gate_drive_enable = wdata[EN_BIT];
		end
		// clear wins over a concurrent write; held clear while the pin stays low
		if (fs_low)
			ctrl_d.gate_drive_enable = 1'h0;
		if (watchdog_clear_i)
			wdg_flag_d = 1'h0;
		// a fault in the clearing cycle is not lost
		if (watchdog_fault_i)
		begin
			wdg_flag_d               = 1'h1;
			ctrl_d.gate_drive_enable = 1'h0;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q     <= CTRL_HI_RESET;
			lower_q    <= LOWER_RESET;
			wdg_flag_q <= 1'h0;
		end
		else
		begin
			ctrl_q     <= ctrl_d;
			lower_q    <= lower_d;
			wdg_flag_q <= wdg_flag_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registered driver outputs
	logic gate_en_d;
	logic recirc_d;

	always_comb
	begin
		gate_en_d = ctrl_q.gate_drive_enable & ~fs_low;
		// free-wheeling only exists in full-bridge topology
		recirc_d  = gate_en_d & ~ctrl_q.bridge_topology_select
			& ctrl_q.active_recirc_enable;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			gate_drivers_enable_o <= 1'h0;
			gate_sink_mode_o      <= 1'h0;
			bridge_topology_o     <= 1'h0;
			active_recirc_o       <= 1'h0;
			watchdog_fault_flag_o <= 1'h0;
			drive_control_o       <= 16'h0000;
		end
		else
		begin
			gate_drivers_enable_o <= gate_en_d;
			gate_sink_mode_o      <= fs_low;
			bridge_topology_o     <= ctrl_q.bridge_topology_select;
			active_recirc_o       <= recirc_d;
			watchdog_fault_flag_o <= wdg_flag_q;
			drive_control_o       <= rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	AST_TOPO_OUT: assert property (@(posedge core_clk_i) disable iff (rst_i)
		1'b1 |=> bridge_topology_o == $past(ctrl_q.bridge_topology_select))
		else $error("topology output does not follow bit 15");
	AST_TOPO_FROZEN: assert property (@(posedge core_clk_i) disable iff (rst_i)
		ctrl_q.gate_drive_enable |=> $stable(ctrl_q.bridge_topology_select))
		else $error("topology changed while enabled");
	AST_OFF_PASSIVE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!ctrl_q.gate_drive_enable |=> !gate_drivers_enable_o)
		else $error("drivers enabled with enable bit clear");
	AST_ON_ACTIVE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		ctrl_q.gate_drive_enable && !fs_low |=> gate_drivers_enable_o)
		else $error("drivers not enabled");
	AST_FS_SINK: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$fell(fs_s2_q) |=> !ctrl_q.gate_drive_enable && gate_sink_mode_o)
		else $error("fail-safe did not force sink and clear enable");
	AST_FS_FREEZE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		fs_low ##1 fs_low |-> !ctrl_q.gate_drive_enable)
		else $error("enable set while fail-safe low");
	AST_WDG_CLEAR: assert property (@(posedge core_clk_i) disable iff (rst_i)
		watchdog_fault_i |=> wdg_flag_q && !ctrl_q.gate_drive_enable ##1 watchdog_fault_flag_o)
		else $error("watchdog fault not handled");
	AST_WDG_FREEZE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wdg_flag_q |=> !$rose(ctrl_q.gate_drive_enable))
		else $error("enable rose under watchdog flag");
	AST_RECIRC_FULL: assert property (@(posedge core_clk_i) disable iff (rst_i)
		gate_en_d && !ctrl_q.bridge_topology_select |=> active_recirc_o == $past(ctrl_q.active_recirc_enable))
		else $error("free-wheeling does not follow bit 13");
	AST_RECIRC_HALF: assert property (@(posedge core_clk_i) disable iff (rst_i)
		ctrl_q.bridge_topology_select |=> !active_recirc_o)
		else $error("free-wheeling active in half-bridge mode");
	AST_ADDR_ONLY: assert property (@(posedge core_clk_i) disable iff (rst_i)
		cs_rise && !addr_hit && !watchdog_fault_i && !fs_low |=> $stable(lower_q) && $stable(ctrl_q))
		else $error("write to another address changed drive control");
	AST_PARTIAL_WRITE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wr_commit |=> {ctrl_q[5:0], lower_q} == $past(wdata[13:0]))
		else $error("writable bits not updated");

endmodule

`default_nettype wire

// ---- bdc_pkg.sv ----
package bdc_pkg;

	// serial frame: write flag, 7-bit address, 16-bit data, msb first
	localparam int unsigned FRAME_BITS   = 24;
	localparam int unsigned ADDR_BITS    = 7;
	localparam int unsigned DATA_BITS    = 16;
	localparam int unsigned WR_BIT       = 23;
	localparam int unsigned ADDR_MSB     = 22;
	localparam int unsigned ADDR_LSB     = 16;
	localparam int unsigned HEAD_BITS    = 8;
	localparam logic [6:0]  DRIVE_CONTROL_ADDR = 7'h03;

	// field positions inside drive_control
	localparam int unsigned TOPO_BIT = 15;
	localparam int unsigned EN_BIT   = 14;
	localparam int unsigned ACTIVE_RECIRC_ENABLE_BIT = 13;

	localparam logic [7:0]  LOWER_RESET = 8'h00;

	typedef struct packed {
		logic bridge_topology_select;
		logic gate_drive_enable;
		logic active_recirc_enable;
		logic recirc_side_select;
		logic leg_one_disable;
		logic leg_two_disable;
		logic drain_monitor_scope;
		logic offstate_openload_test;
	} bdc_ctrl_hi_t;

	localparam bdc_ctrl_hi_t CTRL_HI_RESET = 8'h00;

	// serial pins as seen after the synchronisers
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic mosi;
	} bdc_spi_t;

endpackage

// ---- bdc_spi_host.sv ----
`timescale 1ns/1ps
`default_nettype none

// host side of the serial port: mode 0, sck idle low and still between frames
module bdc_spi_host
(
	// clock
	input  wire logic clk_i,
	// serial pins
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	initial
	begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// five core clocks per sck level, above the three the synchronisers need
	task automatic xfer(input logic [23:0] f, input int n, output logic [15:0] rd);
		int i;
		rd = 16'h0000;
		@(negedge clk_i);
		cs_n_o = 1'b0;
		for (i = 0; i < n; i++)
		begin
			mosi_o = f[23 - i];
			repeat (5) @(negedge clk_i);
			sck_o = 1'b1;
			if (i >= 8)
				rd = {rd[14:0], miso_i};
			repeat (5) @(negedge clk_i);
			sck_o = 1'b0;
		end
		repeat (5) @(negedge clk_i);
		cs_n_o = 1'b1;
		// released line: no stale data left on it
		mosi_o = ~mosi_o;
		repeat (6) @(negedge clk_i);
	endtask
endmodule

`default_nettype wire

// ---- bdc_drive_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module bdc_drive_control_tb;
	import bdc_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        fs_n = 1'b1;
	logic        wdf = 1'b0;
	logic        wdc = 1'b0;
	wire logic   sck;
	wire logic   cs_n;
	wire logic   mosi;
	wire logic   miso;
	wire logic   en;
	wire logic   sink;
	wire logic   topo;
	wire logic   rec;
	wire logic   flag;
	wire logic [15:0] dc;
	wire logic [15:0] st = {11'h000, en, sink, topo, rec, flag};
	logic [15:0] rd;
	int          failures = 0;
	int          num_checks = 0;

	always #5 clk = ~clk;

	bdc_spi_host host_u (.clk_i(clk), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

	bdc_drive_control dut_u (
		.core_clk_i(clk), .rst_i(rst), .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
		.failsafe_input_n_i(fs_n), .watchdog_fault_i(wdf), .watchdog_clear_i(wdc),
		.gate_drivers_enable_o(en), .gate_sink_mode_o(sink), .bridge_topology_o(topo),
		.active_recirc_o(rec), .watchdog_fault_flag_o(flag), .drive_control_o(dc));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e)
		begin
			failures++;
			$display("mismatch %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic test_done;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// commit lands a few clocks after cs rises; eight leaves margin
	task automatic wr(input logic [15:0] d);
		host_u.xfer({1'b1, DRIVE_CONTROL_ADDR, d}, 24, rd);
		repeat (8) @(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////
	// status vector: enable, sink, topology, recirc, watchdog flag
	task automatic t_topo;
		wr(16'hC000);
		chk(st, 16'h0014);
		wr(16'h4000);
		chk(dc, 16'hC000);
		host_u.xfer({1'b0, DRIVE_CONTROL_ADDR, 16'h0000}, 24, rd);
		chk(rd, 16'hC000);
		wr(16'h0000);
		chk(st, 16'h0004);
		wr(16'h0000);
		chk(st, 16'h0000);
	endtask

	task automatic t_rec;
		wr(16'h6000);
		chk(st, 16'h0012);
		wr(16'h4000);
		chk(st, 16'h0010);
		wr(16'h0000);
		wr(16'hE000);
		chk(st, 16'h0014);
		wr(16'h0000);
		wr(16'h0000);
	endtask

	task automatic t_fs;
		wr(16'h40A5);
		fs_n = 1'b0;
		repeat (6) @(negedge clk);
		chk(st, 16'h0008);
		chk(dc, 16'h00A5);
		wr(16'h415A);
		chk(dc, 16'h015A);
		fs_n = 1'b1;
		repeat (4) @(negedge clk);
		wr(16'h4000);
		chk(st, 16'h0010);
	endtask

	task automatic t_wd;
		wdf = 1'b1;
		@(negedge clk);
		wdf = 1'b0;
		repeat (3) @(negedge clk);
		chk(st, 16'h0001);
		wr(16'h40FF);
		chk(dc, 16'h00FF);
		wdc = 1'b1;
		@(negedge clk);
		wdc = 1'b0;
		wr(16'h4000);
		chk(st, 16'h0010);
		wr(16'h0000);
	endtask

	// wrong address and short frame must leave the register alone
	task automatic t_bad;
		host_u.xfer({1'b1, 7'h04, 16'h4000}, 24, rd);
		host_u.xfer({1'b1, DRIVE_CONTROL_ADDR, 16'h4000}, 23, rd);
		repeat (8) @(negedge clk);
		chk(dc, 16'h0000);
		host_u.xfer({1'b0, 7'h04, 16'h0000}, 24, rd);
		chk(rd, 16'h0000);
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		#300us;
		failures++;
		test_done();
	end

	initial
	begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		chk(dc, 16'h0000);
		chk(st, 16'h0000);
		t_topo();
		t_rec();
		t_fs();
		t_wd();
		t_bad();
		test_done();
	end
endmodule

`default_nettype wire
